// ---- design/apsw_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "apsw_consts.svh"

module apsw_regs
    import apsw_pkg::*;
#(
    parameter int LINE_BYTES = `APSW_LINE_BYTES,
    parameter int BEAT_BYTES = `APSW_BEAT_BYTES
) (
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0]                   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]                   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Secondary write beats into main memory
    input  wire logic                          sec_wr_beat_valid,
    input  wire logic [$clog2(LINE_BYTES)-1:0] sec_wr_beat_offset,
    // Bridge controls
    output logic                               sec_wr_line_cut,
    output logic                               secondary_write_stream_disable,
    output logic [1:0]                         aperture_size_bits,
    output logic [1:0]                         aperture_base_bits
);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    typedef enum logic [2:0] {
        SEL_NONE, SEL_BFC, SEL_SIZE, SEL_BASE, SEL_CNT
    } apsw_sel_t;

    // Shared by the read and write paths so both see one map
    function automatic apsw_sel_t decode(input logic [11:0] a);
        if (a == {`APSW_IDX_BFC, 2'b00}) begin
            return SEL_BFC;
        end else if (a == {`APSW_IDX_SIZE, 2'b00}) begin
            return SEL_SIZE;
        end else if (a == `APSW_ADDR_BASE_HI) begin
            return SEL_BASE;
        end else if (a == `APSW_ADDR_CUT_CNT) begin
            return SEL_CNT;
        end else begin
            return SEL_NONE;
        end
    endfunction

    apsw_regs_t  st_reg;
    apsw_regs_t  st_next;
    logic        line_cut;
    logic [15:0] cut_count;
    logic [15:0] bfc_view;
    logic [7:0]  size_view;
    logic [31:0] base_view;
    logic [1:0]  wr_base;
    apsw_sel_t   wsel;
    apsw_sel_t   rsel;
    logic        do_write;

    ////////////////////////////////////////////////////////////////////////////////
    // Line cutter

    apsw_line_cut #(
        .LINE_BYTES (LINE_BYTES),
        .BEAT_BYTES (BEAT_BYTES)
    ) u_cut (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .stream_disable (st_reg.wsd),
        .beat_valid     (sec_wr_beat_valid),
        .beat_offset    (sec_wr_beat_offset),
        .line_cut       (line_cut),
        .cut_count      (cut_count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read views

    // Reserved control bits read back their reset pattern
    assign bfc_view  = (`APSW_BFC_RESET & `APSW_BFC_RSVD_MASK)
                     | (16'(st_reg.wsd) << `APSW_BFC_WSD_BIT);
    assign size_view = 8'(st_reg.size) << `APSW_SIZE_LSB;
    assign base_view = 32'(st_reg.base & st_reg.size) << `APSW_BASE_LSB;
    assign wsel      = decode(st_reg.aw_addr);
    assign rsel      = decode(s_axi_araddr);
    assign do_write  = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    assign wr_base   = st_reg.w_data[`APSW_BASE_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave and registers

    always_comb begin
        st_next = st_reg;
        // Address and data are taken independently, in either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_have = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // Write lands one cycle after both halves are held
        if (do_write) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = `APSW_RESP_OKAY;
            unique case (wsel)
                SEL_BFC: begin
                    if (st_reg.w_strb[`APSW_WSD_LANE]) begin
                        st_next.wsd = st_reg.w_data[`APSW_BFC_WSD_BIT];
                    end
                end
                SEL_SIZE: begin
                    if (st_reg.w_strb[`APSW_SIZE_LANE]) begin
                        st_next.size = st_reg.w_data[`APSW_SIZE_LSB +: 2];
                        // Closing a size bit drops the stored base bit too
                        st_next.base = st_reg.base & st_next.size;
                    end
                end
                SEL_BASE: begin
                    if (st_reg.w_strb[`APSW_BASE_LANE]) begin
                        st_next.base = wr_base & st_reg.size;
                    end
                end
                SEL_CNT: begin
                    // Counter is read-only; the write is accepted and dropped
                end
                SEL_NONE: begin
                    st_next.bresp = `APSW_RESP_SLVERR;
                end
            endcase
        end
        // Read answers one cycle after the address is taken
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = `APSW_RESP_OKAY;
            unique case (rsel)
                SEL_BFC:  st_next.rdata = 32'(bfc_view);
                SEL_SIZE: st_next.rdata = 32'(size_view);
                SEL_BASE: st_next.rdata = base_view;
                SEL_CNT:  st_next.rdata = 32'(cut_count);
                SEL_NONE: begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = `APSW_RESP_SLVERR;
                end
            endcase
        end
        // One write and one read outstanding at most
        st_next.awready = !st_next.aw_have && !st_next.bvalid && !do_write;
        st_next.wready  = !st_next.w_have && !st_next.bvalid && !do_write;
        st_next.arready = !st_next.rvalid;
    end

    // Synchronous reset; ready lines rise the cycle after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg      <= '0;
            st_reg.wsd  <= `APSW_WSD_RESET;
            st_reg.size <= `APSW_SIZE_RESET;
            st_reg.base <= `APSW_BASE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready                  = st_reg.awready;
    assign s_axi_wready                   = st_reg.wready;
    assign s_axi_bvalid                   = st_reg.bvalid;
    assign s_axi_bresp                    = st_reg.bresp;
    assign s_axi_arready                  = st_reg.arready;
    assign s_axi_rvalid                   = st_reg.rvalid;
    assign s_axi_rresp                    = st_reg.rresp;
    assign s_axi_rdata                    = st_reg.rdata;
    assign sec_wr_line_cut                = line_cut;
    assign secondary_write_stream_disable = st_reg.wsd;
    assign aperture_size_bits             = st_reg.size;
    assign aperture_base_bits             = st_reg.base;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_base_write;
        do_write && wsel == SEL_BASE && st_reg.w_strb[`APSW_BASE_LANE];
    endsequence

    sequence s_bfc_read;
        s_axi_arvalid && s_axi_arready && rsel == SEL_BFC;
    endsequence

    sequence s_size_read;
        s_axi_arvalid && s_axi_arready && rsel == SEL_SIZE;
    endsequence

    a_reset_values: assert property (
        @(posedge aclk) !aresetn |=> (st_reg.wsd == 1'b0 && st_reg.size == 2'b00
                                      && st_reg.base == 2'b00))
        else $error("wrong values after reset");

    a_base_forced: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (aperture_base_bits & ~aperture_size_bits) == 2'b00)
        else $error("closed base bit not zero");

    a_base_stores: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_base_write |=> aperture_base_bits == ($past(wr_base) & $past(st_reg.size)))
        else $error("open base bit did not store");

    a_bfc_reserved: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_bfc_read |=> (s_axi_rdata & 32'(`APSW_BFC_RSVD_MASK))
                       == 32'(`APSW_BFC_RESET & `APSW_BFC_RSVD_MASK))
        else $error("reserved control bits not at reset pattern");

    a_size_reserved: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_size_read |=> s_axi_rdata[`APSW_SIZE_LSB-1:0] == '0
                        && s_axi_rdata[31:`APSW_SIZE_LSB+2] == '0)
        else $error("reserved size bits not zero");

    a_write_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write not answered");

endmodule // apsw_regs

`default_nettype wire

// ---- design/apsw_consts.svh ----
// Overview of operation
// - Stream-disable set: cut each secondary write into memory at 32-byte line edge.
// - Stream-disable resets to 0; while 0, writes stream across lines freely.
// - Size bit 0 forces matching aperture base bit to read 0, ignoring writes.
// - Size bit 1 makes matching aperture base bit ordinary read/write storage.
// - Size register resets to 00h; both base bits held zero, 256 MB aperture.
`ifndef APSW_CONSTS_SVH
`define APSW_CONSTS_SVH

// Register indices and their byte addresses (index times four)
`define APSW_IDX_BFC        10'h0B2
`define APSW_IDX_SIZE       10'h0B4
`define APSW_ADDR_BASE_HI   12'h300
`define APSW_ADDR_CUT_CNT   12'h304

// Field positions
`define APSW_BFC_WSD_BIT    10
`define APSW_SIZE_LSB       4
`define APSW_BASE_LSB       26
`define APSW_WSD_LANE       1
`define APSW_SIZE_LANE      0
`define APSW_BASE_LANE      3

// Reset and read-back values
`define APSW_BFC_RESET      16'hE9F0
`define APSW_BFC_RSVD_MASK  16'hFBFF
`define APSW_SIZE_RESET     2'h0
`define APSW_BASE_RESET     2'h0
`define APSW_WSD_RESET      1'h0

// Line geometry of main memory writes
`define APSW_LINE_BYTES     32
`define APSW_BEAT_BYTES     4

// Bus answers
`define APSW_RESP_OKAY      2'h0
`define APSW_RESP_SLVERR    2'h2

`endif

// ---- design/apsw_pkg.sv ----
package apsw_pkg;

    // State of the register bank and its bus slave
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_have;
        logic [11:0] aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        wsd;
        logic [1:0]  size;
        logic [1:0]  base;
    } apsw_regs_t;

    // State of the line cutter
    typedef struct packed {
        logic        cut;
        logic [15:0] count;
    } apsw_cut_t;

endpackage

// ---- design/apsw_line_cut.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "apsw_consts.svh"

module apsw_line_cut
    import apsw_pkg::*;
#(
    parameter int LINE_BYTES = `APSW_LINE_BYTES,
    parameter int BEAT_BYTES = `APSW_BEAT_BYTES
) (
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // Control
    input  wire logic                          stream_disable,
    // Secondary write beats into main memory
    input  wire logic                          beat_valid,
    input  wire logic [$clog2(LINE_BYTES)-1:0] beat_offset,
    // Results
    output logic                               line_cut,
    output logic [15:0]                        cut_count
);

    localparam logic [$clog2(LINE_BYTES)-1:0] LAST_OFF =
        ($clog2(LINE_BYTES))'(LINE_BYTES - BEAT_BYTES);
    localparam logic [$clog2(LINE_BYTES)-1:0] BEAT_MASK =
        ($clog2(LINE_BYTES))'(BEAT_BYTES - 1);

    apsw_cut_t st_reg;
    apsw_cut_t st_next;
    logic      last_beat;

    // A beat that fills the last word of a line closes the line
    assign last_beat = beat_valid && ((beat_offset & ~BEAT_MASK) == LAST_OFF);

    // Cut pulse follows the closing beat; the bridge ends the burst on it
    always_comb begin
        st_next     = st_reg;
        st_next.cut = stream_disable && last_beat;
        if (stream_disable && last_beat) begin
            st_next.count = st_reg.count + 16'h0001;
        end
    end

    // Counter wraps; software reads deltas, so saturation buys nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign line_cut  = st_reg.cut;
    assign cut_count = st_reg.count;

    sequence s_closing_beat;
        stream_disable && last_beat;
    endsequence

    a_cut_at_line: assert property (
        @(posedge aclk) disable iff (!aresetn) s_closing_beat |=> line_cut)
        else $error("line not cut at its last beat");

    a_stream_free: assert property (
        @(posedge aclk) disable iff (!aresetn) !stream_disable |=> !line_cut)
        else $error("cut issued while streaming is allowed");

    a_cut_counted: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_closing_beat |=> cut_count == $past(cut_count) + 16'h0001)
        else $error("cut not counted");

endmodule // apsw_line_cut

`default_nettype wire

// ---- verification/test_aperture_size_write_stream_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "apsw_consts.svh"

module test_aperture_size_write_stream_ctrl import apsw_pkg::*;;
    localparam logic [11:0] A_BFC  = {`APSW_IDX_BFC, 2'h0};
    localparam logic [11:0] A_SIZE = {`APSW_IDX_SIZE, 2'h0};
    localparam logic [11:0] A_BASE = `APSW_ADDR_BASE_HI;
    localparam logic [11:0] A_CNT  = `APSW_ADDR_CUT_CNT;
    localparam logic [1:0]  OK     = `APSW_RESP_OKAY;
    localparam logic [1:0]  ERR    = `APSW_RESP_SLVERR;

    logic        aclk, aresetn;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rnd;
    logic [3:0]  wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, code;
    logic        beat_v, line_cut, wsd_pin, exp_cut;
    logic        cut_due = 1'b0;
    logic [4:0]  beat_off;
    logic [1:0]  size_pin, base_pin;
    logic [1:0]  wq[$];
    logic [33:0] rq[$];
    logic        cq[$];
    int          mismatches, cmp_count, cycles, cut_total;

    apsw_regs uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sec_wr_beat_valid(beat_v), .sec_wr_beat_offset(beat_off),
        .sec_wr_line_cut(line_cut), .secondary_write_stream_disable(wsd_pin),
        .aperture_size_bits(size_pin), .aperture_base_bits(base_pin)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and report
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask

    task automatic chk_resp(input logic [1:0] exp, input logic [1:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask

    // Control pins packed as {disable, size, base}
    task automatic chk_pins(input logic w, input logic [1:0] s, input logic [1:0] b);
        chk_word({27'h0, w, s, b}, {27'h0, wsd_pin, size_pin, base_pin});
    endtask

    task automatic test_done;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus master; both tasks start and end just after a rising edge
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        logic aw_p, w_p, b_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        b_p = 1'b1;
        wq.push_back(er);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Local flags, since the NBA copies only land after this step
        while (b_p) begin
            @(posedge aclk);
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                b_p = 1'b0;
                bready <= 1'b0;
            end
        end
        // Let the release settle before the next request drives the same lines
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_p, r_p;
        ar_p = 1'b1;
        r_p = 1'b1;
        rq.push_back({er, ed});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (r_p) begin
            @(posedge aclk);
            if (ar_p && arready) begin
                ar_p = 1'b0;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                r_p = 1'b0;
                rready <= 1'b0;
            end
        end
        // Let the release settle before the next request drives the same lines
        @(posedge aclk);
    endtask

    // Two lines of back-to-back beats; each line closes on offset 28
    task automatic burst(input logic wsd);
        for (int i = 0; i < 16; i++) begin
            beat_v <= 1'b1;
            beat_off <= 5'(i * 4);
            // One note per beat: a cut is due only after a line's last beat
            cq.push_back(wsd && i % 8 == 7);
            if (wsd && i % 8 == 7) begin
                cut_total++;
            end
            @(posedge aclk);
        end
        beat_v <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and result watcher
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (bvalid && bready) begin
            chk_resp(wq.pop_front(), bresp);
        end
        if (rvalid && rready) begin
            chk_resp(rq[0][33:32], rresp);
            chk_word(rq[0][31:0], rdata);
            void'(rq.pop_front());
        end
        // Each beat owes a note one edge later; a cut with no beat behind it is wrong too
        if (cut_due || line_cut !== 1'b0) begin
            exp_cut = (cut_due && cq.size() > 0) ? cq.pop_front() : 1'b0;
            chk_word({31'h0, exp_cut}, {31'h0, line_cut});
        end
        cut_due = beat_v;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {aresetn, awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready, beat_v, beat_off} = '0;
        {mismatches, cmp_count, cycles, cut_total} = '0;
        rnd = 32'hD20B;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk_pins(1'b0, 2'h0, 2'h0);
        axi_read(A_BFC, 32'h0000E9F0, OK);
        axi_read(A_SIZE, 32'h0, OK);
        rnd = lfsr(rnd);
        axi_write(A_BASE, rnd | 32'h0C000000, 4'hF, OK);
        axi_read(A_BASE, 32'h0, OK);
        // Size codes 3, 2 and 0, with noise in the upper reserved bits
        for (int i = 0; i < 3; i++) begin
            code = (i == 0) ? 2'h3 : (i == 1) ? 2'h2 : 2'h0;
            rnd = lfsr(rnd);
            axi_write(A_SIZE, {rnd[31:6], code, 4'h0}, 4'hF, OK);
            axi_read(A_SIZE, {26'h0, code, 4'h0}, OK);
            axi_write(A_BASE, rnd | 32'h0C000000, 4'hF, OK);
            axi_read(A_BASE, {4'h0, code, 26'h0}, OK);
            chk_pins(1'b0, code, code);
            axi_write(A_BASE, rnd & 32'hF3FFFFFF, 4'hF, OK);
            axi_read(A_BASE, 32'h0, OK);
        end
        // Shrinking the size field must drop the stored lower base bit
        axi_write(A_SIZE, 32'h30, 4'hF, OK);
        axi_write(A_BASE, 32'h0C000000, 4'hF, OK);
        axi_write(A_SIZE, 32'h20, 4'hF, OK);
        axi_read(A_BASE, 32'h08000000, OK);
        chk_pins(1'b0, 2'h2, 2'h2);
        axi_write(12'h010, rnd, 4'hF, ERR);
        axi_read(12'h010, 32'h0, ERR);
        // Streaming allowed, then forced cuts, then allowed again
        burst(1'b0);
        rnd = lfsr(rnd);
        axi_write(A_BFC, rnd | 32'h400, 4'h2, OK);
        axi_read(A_BFC, 32'h0000EDF0, OK);
        chk_pins(1'b1, 2'h2, 2'h2);
        burst(1'b1);
        axi_read(A_CNT, 32'(cut_total), OK);
        axi_write(A_CNT, rnd, 4'hF, OK);
        axi_read(A_CNT, 32'(cut_total), OK);
        axi_write(A_BFC, 32'h0, 4'h2, OK);
        chk_pins(1'b0, 2'h2, 2'h2);
        // Control lane strobe off: the disable bit must not move
        axi_write(A_BFC, 32'h400, 4'hD, OK);
        chk_pins(1'b0, 2'h2, 2'h2);
        burst(1'b0);
        axi_read(A_CNT, 32'(cut_total), OK);
        chk_word(32'h0, 32'(cq.size()));
        test_done();
    end
endmodule // test_aperture_size_write_stream_ctrl

`default_nettype wire
